// ===== ifs_defines.svh
// Offsets, field positions, reset values, fault codes and timing for the fault supervisor
`ifndef IFS_DEFINES_SVH
`define IFS_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define IFS_REG_CTRL        5'h00
`define IFS_REG_STATUS      5'h04
`define IFS_REG_FAULT_CODE  5'h08
`define IFS_REG_WARN_CODE   5'h0C

// ==========================================================================
// Field positions
`define IFS_CTRL_CLEAR_BIT  0
`define IFS_CTRL_ROUTE_BIT  1
`define IFS_ST_STATE_LSB    0
`define IFS_ST_PERM_BIT     2
`define IFS_ST_MSG_BIT      3
`define IFS_ST_KNOWN_BIT    4
`define IFS_ST_ZERO_BIT     5

// ==========================================================================
// Reset values
`define IFS_ROUTE_RST       1'h0
`define IFS_CODE_RST        8'h00
`define IFS_WARN_RST        7'h00

// ==========================================================================
// Warning weights, one bit each
`define IFS_WARN_BATTERY    0
`define IFS_WARN_TRIP_CIRC  1
`define IFS_WARN_PSU_TEMP   2
`define IFS_WARN_COMM       3
`define IFS_WARN_PROT_CFG   4
`define IFS_WARN_PROT_MOD   5
`define IFS_WARN_LIGHT      6

// ==========================================================================
// Internal fault codes
`define IFS_FC_HEAVY_FIRST  8'h04
`define IFS_FC_SIG_LAST     8'h08
`define IFS_FC_BASE_ENABLE  8'h09
`define IFS_FC_BASE_FB_LO   8'h0A
`define IFS_FC_BASE_FB_HI   8'h0C
`define IFS_FC_OPT_FIRST    8'h0D
`define IFS_FC_OPT_LAST     8'h0F
`define IFS_FC_OPT_ENABLE   8'h10
`define IFS_FC_OPT_FB_LO    8'h11
`define IFS_FC_OPT_FB_HI    8'h13
`define IFS_FC_AUX_DIP_LO   8'h14
`define IFS_FC_AUX_DIP_HI   8'h15
`define IFS_FC_PROG_MEM     8'h1E
`define IFS_FC_WORK_MEM_A   8'h32
`define IFS_FC_WORK_MEM_B   8'h3B
`define IFS_FC_PARAM_LO     8'h33
`define IFS_FC_PARAM_HI     8'h36
`define IFS_FC_CALIB        8'h37
`define IFS_FC_PARAM_EXTRA  8'h38
`define IFS_FC_IO_MISSING   8'h50
`define IFS_FC_IO_UNKNOWN   8'h51
`define IFS_FC_IO_CONFIG    8'h52
`define IFS_FC_PSU_FAULTY   8'h55
`define IFS_FC_PSU_UNKNOWN  8'h56
`define IFS_FC_HW_CONFIG    8'h5A
`define IFS_FC_COMM_UNKNOWN 8'h5F
`define IFS_FC_PROT_SET     8'h68
`define IFS_FC_VREF_A       8'h83
`define IFS_FC_VREF_B       8'h8B
`define IFS_FC_VREF_C       8'hC3
`define IFS_FC_VREF_D       8'hCB
`define IFS_FC_VREF_E       8'hDE
`define IFS_FC_VREF_F       8'hDF
`define IFS_FC_LIGHT_TWO    8'hF0
`define IFS_FC_LIGHT_ONE    8'hF1
`define IFS_FC_MEAS_UNIT    8'hFD

// ==========================================================================
// Timing
`define IFS_CLK_HZ          50000000
`define IFS_RESTART_US      100
`define IFS_SETTLE_US       20
`define IFS_BLINK_HALF_MS   250

`endif

// ===== ifs_pkg.sv
// Types shared by the fault supervisor and its bench
package ifs_pkg;

  // ========================================================================
  // Supervision states
  typedef enum logic [1:0] {
    IFS_NORMAL,
    IFS_RESTART,
    IFS_SETTLE,
    IFS_PERM
  } ifs_state_t;

  // ========================================================================
  // Display source
  typedef enum logic [1:0] {
    IFS_DISP_NONE,
    IFS_DISP_INTERNAL,
    IFS_DISP_WARNING
  } ifs_disp_kind_t;

  typedef struct packed {
    ifs_disp_kind_t kind;
    logic [7:0]     code;
  } ifs_disp_t;

  // ========================================================================
  // Output contacts other than the supervision contact
  typedef struct packed {
    logic [4:0] signal_out;
    logic [2:0] heavy_out;
  } ifs_contacts_t;

endpackage : ifs_pkg

// ===== ifs_supervisor.sv
// Internal fault supervisor: restart, lock-out, indicators, fault codes, register slave
//
// The Avalon-MM slave port and the register offsets were decided locally.
`include "ifs_defines.svh"

// Functional notes
// - On an internal fault, restart first; declare permanent only if it persists.
// - Permanent fault blinks ready indicator and activates the supervision contact.
// - Permanent fault forces other contacts to initial state and locks them.
// - Permanent fault shows a display message with its numeric fault code; a message still held keeps the earlier code.
// - Internal fault message has top display priority over all other sources.
// - Clear requests are ignored while the ready indicator blinks.
// - Fault gone: stop blinking, resume service, keep message until cleared.
// - Codes 4-6 heavy outputs one-three, 7-8 signal outputs one-two.
// - Code 9 base enable error; 10-12 base feedback, enable or relay error.
// - Codes 13-15 optional outputs, 16 their enable, 17-19 their feedback.
// - Memory codes 30, 50/59, 51-54/56, 55; auxiliary dips 20 or 21.
// - Module codes 80, 81, 82, 85, 86, 90 and 95.
// - Codes 104, reference voltage set, 240, 241 and 253.
// - Parameter memory fault active forces user settings to zero.
// - Warnings keep operation and leave the ready indicator steadily lit.
// - Warning code combines all active warnings into one value.
// - Warning message cannot be cleared; it vanishes with its fault.
// - Warning weights 1,2,4,8,16,32,64; combined maximum 127.
// - Trip-circuit and light warnings route to signal output two when switched.
// - Supervision contact energized in normal service; drops on permanent fault.
module ifs_supervisor #(
  parameter int unsigned RESTART_CYC    = `IFS_RESTART_US * (`IFS_CLK_HZ / 1000000),
  parameter int unsigned BLINK_HALF_CYC = `IFS_BLINK_HALF_MS * (`IFS_CLK_HZ / 1000)
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  // Avalon-MM slave
  input  wire logic [4:0]            avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic      [31:0]           avs_readdata_o,
  output logic                       avs_waitrequest_o,
  // Fault and warning sources
  input  wire logic                  fault_valid_i,
  input  wire logic [7:0]            fault_code_i,
  input  wire logic [6:0]            warn_flags_i,
  input  wire ifs_pkg::ifs_contacts_t contact_req_i,
  // Panel and relay drivers
  output logic                       restart_o,
  output logic                       ready_led_o,
  output logic                       supervision_coil_o,
  output ifs_pkg::ifs_contacts_t     contact_o,
  output ifs_pkg::ifs_disp_t         disp_o,
  output logic                       settings_zero_o
);

  localparam int unsigned SETTLE_CYC = `IFS_SETTLE_US * (`IFS_CLK_HZ / 1000000);
  localparam int unsigned CNT_W      = 24;

  // ========================================================================
  // Fault code decoding
  function automatic logic is_param_mem(input logic [7:0] code);
    is_param_mem = (code >= `IFS_FC_PARAM_LO && code <= `IFS_FC_PARAM_HI) ||
                   code == `IFS_FC_PARAM_EXTRA;
  endfunction

  function automatic logic is_known_code(input logic [7:0] code);
    logic k;
    k = 1'b0;
    if (code >= `IFS_FC_HEAVY_FIRST && code <= `IFS_FC_SIG_LAST) begin
      k = 1'b1;
    end
    if (code == `IFS_FC_BASE_ENABLE ||
        (code >= `IFS_FC_BASE_FB_LO && code <= `IFS_FC_BASE_FB_HI)) begin
      k = 1'b1;
    end
    if ((code >= `IFS_FC_OPT_FIRST && code <= `IFS_FC_OPT_LAST) ||
        code == `IFS_FC_OPT_ENABLE ||
        (code >= `IFS_FC_OPT_FB_LO && code <= `IFS_FC_OPT_FB_HI)) begin
      k = 1'b1;
    end
    if (code == `IFS_FC_AUX_DIP_LO || code == `IFS_FC_AUX_DIP_HI ||
        code == `IFS_FC_PROG_MEM || code == `IFS_FC_WORK_MEM_A ||
        code == `IFS_FC_WORK_MEM_B || code == `IFS_FC_CALIB ||
        is_param_mem(code)) begin
      k = 1'b1;
    end
    if (code == `IFS_FC_IO_MISSING || code == `IFS_FC_IO_UNKNOWN ||
        code == `IFS_FC_IO_CONFIG || code == `IFS_FC_PSU_FAULTY ||
        code == `IFS_FC_PSU_UNKNOWN || code == `IFS_FC_HW_CONFIG ||
        code == `IFS_FC_COMM_UNKNOWN) begin
      k = 1'b1;
    end
    if (code == `IFS_FC_PROT_SET || code == `IFS_FC_VREF_A ||
        code == `IFS_FC_VREF_B || code == `IFS_FC_VREF_C ||
        code == `IFS_FC_VREF_D || code == `IFS_FC_VREF_E ||
        code == `IFS_FC_VREF_F || code == `IFS_FC_LIGHT_TWO ||
        code == `IFS_FC_LIGHT_ONE || code == `IFS_FC_MEAS_UNIT) begin
      k = 1'b1;
    end
    is_known_code = k;
  endfunction

  // ========================================================================
  // Register bus slave
  logic             waitreq_q;
  logic [31:0]      readdata_q;
  logic             route_q;
  logic             clear_q;
  logic             bus_write;
  logic             bus_read_prep;
  logic [31:0]      read_mux;

  ifs_pkg::ifs_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic             msg_valid_q;
  logic [7:0]       msg_code_q;
  logic [6:0]       warn_q;
  logic             settings_zero_q;

  // Write lands only at the edge where the master sees waitrequest low
  assign bus_write     = avs_write_i && !waitreq_q;
  assign bus_read_prep = avs_read_i && waitreq_q;

  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (avs_address_i)
      `IFS_REG_CTRL: begin
        read_mux[`IFS_CTRL_ROUTE_BIT] = route_q;
      end
      `IFS_REG_STATUS: begin
        read_mux[`IFS_ST_STATE_LSB +: 2] = state_q;
        read_mux[`IFS_ST_PERM_BIT]       = (state_q == ifs_pkg::IFS_PERM);
        read_mux[`IFS_ST_MSG_BIT]        = msg_valid_q;
        read_mux[`IFS_ST_KNOWN_BIT]      = is_known_code(msg_code_q);
        read_mux[`IFS_ST_ZERO_BIT]       = settings_zero_q;
      end
      `IFS_REG_FAULT_CODE: begin
        read_mux[7:0] = msg_code_q;
      end
      `IFS_REG_WARN_CODE: begin
        read_mux[6:0] = warn_q;
      end
      default: begin
        read_mux = 32'h0000_0000;
      end
    endcase
  end

  // One wait cycle per access; waitrequest idles high
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      waitreq_q <= 1'b1;
    end else begin
      waitreq_q <= !((avs_read_i || avs_write_i) && waitreq_q);
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      readdata_q <= 32'h0000_0000;
    end else if (bus_read_prep) begin
      readdata_q <= read_mux;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      route_q <= `IFS_ROUTE_RST;
    end else if (bus_write && avs_address_i == `IFS_REG_CTRL && avs_byteenable_i[0]) begin
      route_q <= avs_writedata_i[`IFS_CTRL_ROUTE_BIT];
    end
  end

  // Clear is a one-cycle command, never stored beyond this pulse
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      clear_q <= 1'b0;
    end else begin
      clear_q <= bus_write && avs_address_i == `IFS_REG_CTRL &&
                 avs_byteenable_i[0] && avs_writedata_i[`IFS_CTRL_CLEAR_BIT];
    end
  end

  assign avs_waitrequest_o = waitreq_q;
  assign avs_readdata_o    = readdata_q;

  // ========================================================================
  // Restart and permanence decision
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ifs_pkg::IFS_NORMAL;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        ifs_pkg::IFS_NORMAL: begin
          cnt_q <= '0;
          if (fault_valid_i) begin
            state_q <= ifs_pkg::IFS_RESTART;
          end
        end
        ifs_pkg::IFS_RESTART: begin
          if (cnt_q == CNT_W'(RESTART_CYC - 1)) begin
            cnt_q   <= '0;
            state_q <= ifs_pkg::IFS_SETTLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ifs_pkg::IFS_SETTLE: begin
          // Fault still present after the restart settles means permanent
          if (cnt_q == CNT_W'(SETTLE_CYC - 1)) begin
            cnt_q   <= '0;
            state_q <= fault_valid_i ? ifs_pkg::IFS_PERM : ifs_pkg::IFS_NORMAL;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ifs_pkg::IFS_PERM: begin
          if (!fault_valid_i) begin
            state_q <= ifs_pkg::IFS_NORMAL;
          end
        end
      endcase
    end
  end

  logic enter_perm;
  assign enter_perm = (state_q == ifs_pkg::IFS_SETTLE) && fault_valid_i &&
                      (cnt_q == CNT_W'(SETTLE_CYC - 1));

  // ========================================================================
  // Held fault message
  // A clear in the cycle a fault turns permanent loses: the message is set, any held code kept.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      msg_valid_q <= 1'b0;
      msg_code_q  <= `IFS_CODE_RST;
    end else if (enter_perm) begin
      msg_valid_q <= 1'b1;
      if (!msg_valid_q) begin
        msg_code_q <= fault_code_i;
      end
    end else if (clear_q && state_q != ifs_pkg::IFS_PERM) begin
      msg_valid_q <= 1'b0;
      msg_code_q  <= `IFS_CODE_RST;
    end
  end

  // Warning code is the live OR of the weight bits, no clear path
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      warn_q <= `IFS_WARN_RST;
    end else begin
      warn_q <= warn_flags_i;
    end
  end

  // ========================================================================
  // Indicators and contacts
  logic [CNT_W-1:0] blink_cnt_q;
  logic             blink_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b1;
    end else if (state_q != ifs_pkg::IFS_PERM) begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b1;
    end else if (blink_cnt_q == CNT_W'(BLINK_HALF_CYC - 1)) begin
      blink_cnt_q <= '0;
      blink_q     <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_led_o        <= 1'b1;
      supervision_coil_o <= 1'b0;
      restart_o          <= 1'b0;
    end else begin
      // Steady lit for normal service and warnings alike
      ready_led_o        <= (state_q == ifs_pkg::IFS_PERM) ? blink_q : 1'b1;
      supervision_coil_o <= (state_q != ifs_pkg::IFS_PERM);
      restart_o          <= (state_q == ifs_pkg::IFS_RESTART);
    end
  end

  // Coil stays de-energized during reset, which reads as a fault to the field
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      contact_o <= '0;
    end else if (state_q == ifs_pkg::IFS_PERM) begin
      contact_o <= '0;
    end else begin
      contact_o <= contact_req_i;
      contact_o.signal_out[1] <= contact_req_i.signal_out[1] ||
                                 (route_q && (warn_flags_i[`IFS_WARN_TRIP_CIRC] ||
                                              warn_flags_i[`IFS_WARN_LIGHT]));
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      settings_zero_q <= 1'b0;
    end else begin
      settings_zero_q <= (state_q == ifs_pkg::IFS_PERM) && is_param_mem(fault_code_i);
    end
  end

  assign settings_zero_o = settings_zero_q;

  // ========================================================================
  // Display selection
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      disp_o <= '{kind: ifs_pkg::IFS_DISP_NONE, code: `IFS_CODE_RST};
    end else if (msg_valid_q) begin
      disp_o <= '{kind: ifs_pkg::IFS_DISP_INTERNAL, code: msg_code_q};
    end else if (warn_q != `IFS_WARN_RST) begin
      disp_o <= '{kind: ifs_pkg::IFS_DISP_WARNING, code: {1'b0, warn_q}};
    end else begin
      disp_o <= '{kind: ifs_pkg::IFS_DISP_NONE, code: `IFS_CODE_RST};
    end
  end

endmodule // ifs_supervisor

// ===== ifs_supervisor_assertions.sv
// Port-level assertions for the fault supervisor, bound to its top module
module ifs_supervisor_assertions #(
  parameter int unsigned RESTART_CYC    = 8,
  parameter int unsigned BLINK_HALF_CYC = 4
) (
  input wire logic                   mclk_i,
  input wire logic                   rst_i,
  input wire logic                   avs_read_i,
  input wire logic                   avs_write_i,
  input wire logic                   avs_waitrequest_o,
  input wire logic [6:0]             warn_flags_i,
  input wire logic                   restart_o,
  input wire logic                   ready_led_o,
  input wire logic                   supervision_coil_o,
  input wire ifs_pkg::ifs_contacts_t contact_o,
  input wire ifs_pkg::ifs_disp_t     disp_o,
  input wire logic                   settings_zero_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // Helper counters: restart length and how long the lamp holds one level
  int unsigned rcnt_q;
  int unsigned lcnt_q;
  logic        led_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rcnt_q <= 0;
      lcnt_q <= 0;
      led_q  <= 1'b1;
    end else begin
      rcnt_q <= restart_o ? rcnt_q + 1 : 0;
      led_q  <= ready_led_o;
      lcnt_q <= (supervision_coil_o || ready_led_o != led_q) ? 0 : lcnt_q + 1;
    end
  end
  // ==========================================================================
  // Properties
  sequence perm_in_s;
    $fell(supervision_coil_o);
  endsequence
  sequence restart_end_s;
    $fell(restart_o);
  endsequence
  restart_len_a: assert property (restart_end_s |-> rcnt_q == RESTART_CYC)
    else $error("restart pulse length wrong");
  restart_coil_a: assert property (restart_o |-> supervision_coil_o)
    else $error("coil dropped during restart");
  perm_lock_a: assert property (!supervision_coil_o |-> contact_o == 8'h00)
    else $error("contacts not locked");
  disp_first_a: assert property (perm_in_s |-> ##[0:2] disp_o.kind == ifs_pkg::IFS_DISP_INTERNAL)
    else $error("no internal message");
  disp_hold_a: assert property (!supervision_coil_o && disp_o.kind == ifs_pkg::IFS_DISP_INTERNAL |=>
    disp_o.kind == ifs_pkg::IFS_DISP_INTERNAL && $stable(disp_o.code))
    else $error("internal message replaced");
  msg_kept_a: assert property ($rose(supervision_coil_o) &&
    $past(disp_o.kind) == ifs_pkg::IFS_DISP_INTERNAL |-> disp_o.kind == ifs_pkg::IFS_DISP_INTERNAL)
    else $error("message lost on recovery");
  led_steady_a: assert property (supervision_coil_o [*3] |-> ready_led_o)
    else $error("lamp not steady");
  blink_rate_a: assert property (lcnt_q <= BLINK_HALF_CYC + 2)
    else $error("lamp not blinking");
  warn_code_a: assert property (disp_o.kind == ifs_pkg::IFS_DISP_WARNING |->
    disp_o.code == {1'b0, $past(warn_flags_i, 2)})
    else $error("warning code wrong");
  zero_perm_a: assert property (settings_zero_o |-> ##[0:1] !supervision_coil_o)
    else $error("settings zeroed outside fault");
  bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
    !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer timing wrong");
endmodule : ifs_supervisor_assertions

bind ifs_supervisor ifs_supervisor_assertions #(
  .RESTART_CYC(RESTART_CYC),
  .BLINK_HALF_CYC(BLINK_HALF_CYC)
) ifs_chk_u (
  .mclk_i             (mclk_i),
  .rst_i              (rst_i),
  .avs_read_i         (avs_read_i),
  .avs_write_i        (avs_write_i),
  .avs_waitrequest_o  (avs_waitrequest_o),
  .warn_flags_i       (warn_flags_i),
  .restart_o          (restart_o),
  .ready_led_o        (ready_led_o),
  .supervision_coil_o (supervision_coil_o),
  .contact_o          (contact_o),
  .disp_o             (disp_o),
  .settings_zero_o    (settings_zero_o)
);

// ===== ifs_panel_model.sv
// Front panel stand-in: counts ready lamp changes and latches the shown code
module ifs_panel_model (
  input  wire logic               mclk_i,
  input  wire logic               rst_i,
  input  wire logic               ready_led_i,
  input  wire ifs_pkg::ifs_disp_t disp_i,
  output int                      toggles_o,
  output logic [7:0]              shown_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic led_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      led_q     <= 1'b1;
      toggles_o <= 0;
      shown_o   <= 8'h00;
    end else begin
      led_q <= ready_led_i;
      if (led_q != ready_led_i) toggles_o <= toggles_o + 1;
      if (disp_i.kind != ifs_pkg::IFS_DISP_NONE) shown_o <= disp_i.code;
    end
  end
endmodule : ifs_panel_model

// ===== internal_fault_supervisor_bench.sv
// Self-checking bench for the fault supervisor
module internal_fault_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   mclk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   rd = 1'b0;
  logic                   wr = 1'b0;
  logic                   fv = 1'b0;
  logic                   wq, rs, led, coil, sz, rt, kx;
  logic [4:0]             adr = 5'h00;
  logic [31:0]            wd = 32'h0;
  logic [31:0]            rdat, q;
  logic [7:0]             fc = 8'h00;
  logic [7:0]             c, shown;
  logic [6:0]             wf = 7'h00;
  ifs_pkg::ifs_contacts_t req = 8'h00;
  ifs_pkg::ifs_contacts_t con, e;
  ifs_pkg::ifs_disp_t     disp;
  int                     n_mismatch = 0;
  int                     n_checks = 0;
  int                     cyc = 0;
  int                     tog, t0, w;
  // The last two codes are outside every table and must read back as unknown
  logic [7:0] codes[20] = '{8'h04, 8'h08, 8'h09, 8'h0C, 8'h0D, 8'h10, 8'h13, 8'h15, 8'h1E,
                            8'h33, 8'h38, 8'h37, 8'h3B, 8'h52, 8'h5F, 8'h68, 8'hDF, 8'hFD,
                            8'h02, 8'hC4};
  logic [4:0] ra[6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h1C};

  ifs_supervisor #(.RESTART_CYC(8), .BLINK_HALF_CYC(4)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .fault_valid_i(fv),
    .fault_code_i(fc), .warn_flags_i(wf), .contact_req_i(req), .restart_o(rs),
    .ready_led_o(led), .supervision_coil_o(coil), .contact_o(con), .disp_o(disp),
    .settings_zero_o(sz));
  ifs_panel_model panel (.mclk_i(mclk_i), .rst_i(rst_i), .ready_led_i(led),
    .disp_i(disp), .toggles_o(tog), .shown_o(shown));

  always #10 mclk_i = ~mclk_i;
  // Cuts a hang short; the full run needs about 25000 cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ==========================================================================
  // Shared tasks and the display model
  task automatic end_of_test();
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // Holds the request until waitrequest is sampled low, then releases it;
  // a slave that never answers is caught by the cycle ceiling above
  task automatic bus(input logic w1, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    adr <= a;
    wd  <= d;
    rd  <= !w1;
    wr  <= w1;
    do begin
      @(posedge mclk_i);
    end while (wq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  function automatic logic [9:0] dexp(int held, int code, int wv);
    if (held != 0) return {ifs_pkg::IFS_DISP_INTERNAL, code[7:0]};
    if (wv != 0) return {ifs_pkg::IFS_DISP_WARNING, 1'b0, wv[6:0]};
    return 10'h000;
  endfunction
  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(86));
    tick(8);
    rst_i <= 1'b0;
    tick(2);
    bus(1'b1, 5'h14, 32'hFFFFFFFF);
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0);
      chk(q, 32'h0);
    end
    chk({coil, led}, 2'b11);
    // Warnings: combined code, no manual clear, routing to signal output two
    for (int i = 0; i < 8; i++) begin
      w = (i == 7) ? 127 : $urandom_range(0, 127);
      rt = i[0];
      wf <= w[6:0];
      req <= 8'($urandom);
      bus(1'b1, 5'h00, {30'h0, rt, 1'b0});
      tick(3);
      chk(disp, dexp(0, 0, w));
      bus(1'b0, 5'h0C, 32'h0);
      chk(q, w);
      bus(1'b1, 5'h00, {30'h0, rt, 1'b1});
      tick(5);
      chk(disp, dexp(0, 0, w));
      e = req;
      e.signal_out[1] = e.signal_out[1] | (rt & (w[1] | w[6]));
      chk(con, e);
    end
    bus(1'b1, 5'h00, 32'h0);
    // Transient fault recovers by restart
    fv <= 1'b1;
    fc <= 8'h04;
    tick(3);
    chk(rs, 1'b1);
    fv <= 1'b0;
    tick(1100);
    chk({coil, disp}, {1'b1, dexp(0, 0, wf)});
    // Permanent faults, one per code
    foreach (codes[i]) begin
      c = codes[i];
      fv <= 1'b1;
      fc <= c;
      tick(500);
      chk(coil, 1'b1);
      tick(530);
      t0 = tog;
      chk({coil, con}, 9'h000);
      chk(disp, dexp(1, c, 0));
      chk(sz, c inside {[8'h33:8'h36], 8'h38});
      kx = c inside {[4:21], 30, [50:56], 59, 80, 81, 82, 85, 86, 90, 95, 104,
                     131, 139, 195, 203, 222, 223, 240, 241, 253};
      bus(1'b0, 5'h04, 32'h0);
      chk(q, {26'h0, c inside {[51:54], 56}, kx, 4'hF});
      fc <= ~c;
      wf <= 7'($urandom);
      bus(1'b1, 5'h00, 32'h1);
      tick(12);
      chk(disp, dexp(1, c, 0));
      chk(shown, c);
      chk(tog - t0 >= 2, 1'b1);
      bus(1'b0, 5'h08, 32'h0);
      chk(q, c);
      fv <= 1'b0;
      tick(4);
      chk({coil, led, con}, {2'b11, req});
      chk(disp, dexp(1, c, 0));
      bus(1'b1, 5'h00, 32'h1);
      tick(5);
      chk(disp, dexp(0, 0, wf));
    end
    // A second permanent fault before any clear keeps the first code on show
    for (int k = 0; k < 2; k++) begin
      fv <= 1'b1;
      fc <= codes[k];
      tick(1030);
      fv <= 1'b0;
      tick(4);
    end
    chk(disp, dexp(1, codes[0], 0));
    end_of_test();
  end
endmodule : internal_fault_supervisor_bench
